// ---- hdl/mmc_timeout_block_count.sv ----
// time-out counters, block counters, event flags and masks behind a classic wishbone slave
// assumes card pins are asynchronous levels and ctrl_ev pulses come from logic on core_clk
// Functional notes
// R1: mask bit 4 enables response time-out interrupt
// R2: mask bit 3 enables read time-out interrupt
// R3: mask bit 2 enables command done interrupt
// R4: mask bit 1 enables busy done interrupt
// R5: mask bit 0 enables data done interrupt
// R6: response wait counts programmed card clocks
// R7: response limit zero disables the time-out
// R8: enabled response time-out flag raises interrupt
// R9: upper read limit bits join lower sixteen
// R10: read wait counts programmed card clocks
// R11: combined read limit zero disables time-out
// R12: enabled read time-out flag raises interrupt
// R13: block length twelve bits, never zero
// R14: software matches card block length setting
// R15: block count zero runs until stop
// R16: nonzero count stops after n blocks
// R17: readable down-counter of remaining blocks
// R18: interrupt only on flag rising edge
// R19: counter loads at start, decrements per block
// R20: time-out counters restart, stop on start bit
`timescale 1ns/1ps
`include "mmc_tobc_params.svh"
module mmc_timeout_block_count (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // card pins
  input wire mmc_tobc_pkg::card_pins_t card_pins,
  // engine events
  input wire mmc_tobc_pkg::ctrl_events_t ctrl_ev,
  // results
  output logic irq_o,
  output logic xfer_active_o,
  output logic xfer_stop_o,
  output logic [11:0] blk_len_o
);

  // byte-lane merge used by every writable register
  function automatic logic [31:0] apply_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // pin synchronisers, first stage read only by the second
  logic [2:0] pin_s1_reg, pin_s2_reg;
  logic clk_prev_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      clk_prev_reg <= 1'b1;
    end else begin
      pin_s1_reg <= card_pins;
      pin_s2_reg <= pin_s1_reg;
      clk_prev_reg <= pin_s2_reg[2];
    end
  end

  // card clock rising edge and start bits seen on it
  wire card_tick = pin_s2_reg[2] & ~clk_prev_reg;
  wire resp_arrive = card_tick & ~pin_s2_reg[1];
  wire data_arrive = card_tick & ~pin_s2_reg[0];

  // registers
  logic [4:0] mask_reg, mask_next;
  logic [15:0] tor_reg, tor_next;
  logic [15:0] tod_reg, tod_next;
  logic [11:0] block_byte_count_reg, block_byte_count_next;
  logic [15:0] blocks_to_transfer_reg, blocks_to_transfer_next;
  logic [15:0] left_reg, left_next;
  logic [4:0] flags_reg, flags_next;
  logic irq_reg, irq_next;
  logic stop_reg;
  logic inf_reg, inf_next;
  logic done_ev;
  mmc_tobc_pkg::xfer_state_t xstate_reg, xstate_next;
  logic ack_reg;
  logic [31:0] dat_reg;

  // bus decode
  wire req = cyc_i & stb_i;
  wire [7:0] adr_w = {adr_i[7:2], 2'b00};
  wire hit_mask = (adr_w == `OFS_IRQ_MASK);
  wire hit_tor = (adr_w == `OFS_RESP_TO);
  wire hit_tod = (adr_w == `OFS_READ_TO);
  wire hit_block_byte_count = (adr_w == `OFS_BLK_LEN);
  wire hit_blocks_to_transfer = (adr_w == `OFS_BLK_CNT);
  wire hit_left = (adr_w == `OFS_BLK_LEFT);
  wire hit_stat = (adr_w == `OFS_STATUS);
  // a write lands only on the edge where ack is seen
  wire wr_go = req & we_i & ack_reg;

  // merged write values
  wire [31:0] mask_wr = apply_sel({27'h0000000, mask_reg}, dat_i, sel_i);
  wire [31:0] tor_wr = apply_sel({16'h0000, tor_reg}, dat_i, sel_i);
  wire [31:0] tod_wr = apply_sel({16'h0000, tod_reg}, dat_i, sel_i);
  wire [31:0] block_byte_count_wr = apply_sel({20'h00000, block_byte_count_reg}, dat_i, sel_i);
  wire [31:0] blocks_to_transfer_wr = apply_sel({16'h0000, blocks_to_transfer_reg}, dat_i, sel_i);
  wire [31:0] clr_wr = apply_sel(32'h00000000, dat_i, sel_i);

  // R1 R2 R3 R4 R5 enable bits stored per event
  assign mask_next = (wr_go & hit_mask) ? mask_wr[4:0] : mask_reg;
  assign tor_next = (wr_go & hit_tor) ? tor_wr[15:0] : tor_reg;
  assign tod_next = (wr_go & hit_tod) ? tod_wr[15:0] : tod_reg;
  // R13 a zero length write is dropped
  assign block_byte_count_next = (wr_go & hit_block_byte_count & (block_byte_count_wr[11:0] != 12'h000)) ? block_byte_count_wr[11:0] : block_byte_count_reg;
  assign blocks_to_transfer_next = (wr_go & hit_blocks_to_transfer) ? blocks_to_transfer_wr[15:0] : blocks_to_transfer_reg;

  // time-out waits
  logic resp_expired, read_expired;
  // R9 upper bits joined above the lower sixteen
  wire [23:0] read_limit = {tor_reg[15:8], tod_reg};
  wire [23:0] resp_limit = {16'h0000, tor_reg[7:0]};

  // R6 R7 response wait in card clocks
  mmc_wait_timer resp_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(ctrl_ev.cmd_sent),
    .limit(resp_limit),
    .tick(card_tick),
    .arrive(resp_arrive),
    .waiting(),
    .expired(resp_expired)
  );

  // R10 R11 read wait, zero combined limit disables it
  mmc_wait_timer read_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(ctrl_ev.read_wait),
    .limit(read_limit),
    .tick(card_tick),
    .arrive(data_arrive),
    .waiting(),
    .expired(read_expired)
  );

  // transfer sequencing and remaining-block count
  always_comb begin
    xstate_next = xstate_reg;
    left_next = left_reg;
    inf_next = inf_reg;
    done_ev = 1'b0;
    case (xstate_reg)
      mmc_tobc_pkg::XFER_IDLE: begin
        if (ctrl_ev.xfer_start) begin
          // R19 load at transfer start
          xstate_next = mmc_tobc_pkg::XFER_RUN;
          left_next = blocks_to_transfer_reg;
          inf_next = (blocks_to_transfer_reg == 16'h0000);
        end
      end
      mmc_tobc_pkg::XFER_RUN: begin
        if (ctrl_ev.stop_cmd) begin
          // R15 stop command ends any transfer
          xstate_next = mmc_tobc_pkg::XFER_IDLE;
          done_ev = 1'b1;
        end else if (ctrl_ev.block_done && !inf_reg) begin
          // R17 R19 one less per block
          left_next = left_reg - 16'h0001;
          if (left_reg == 16'h0001) begin
            // R16 stop after n blocks
            xstate_next = mmc_tobc_pkg::XFER_IDLE;
            done_ev = 1'b1;
          end
        end
      end
      default: xstate_next = mmc_tobc_pkg::XFER_IDLE;
    endcase
  end

  // event flags: a new event beats a same-cycle clear
  wire [4:0] ev_set = {resp_expired, read_expired, ctrl_ev.resp_end, ctrl_ev.busy_end, done_ev};
  wire [4:0] flag_clr = (wr_go & hit_stat) ? clr_wr[4:0] : 5'h00;
  assign flags_next = (flags_reg & ~flag_clr) | ev_set;
  // R8 R12 R18 only a fresh rising flag under its enable
  assign irq_next = |(flags_next & ~flags_reg & mask_reg);

  // read mux, unmapped words read zero
  wire [31:0] rd_word =
    hit_mask ? {27'h0000000, mask_reg} :
    hit_tor ? {16'h0000, tor_reg} :
    hit_tod ? {16'h0000, tod_reg} :
    hit_block_byte_count ? {20'h00000, block_byte_count_reg} :
    hit_blocks_to_transfer ? {16'h0000, blocks_to_transfer_reg} :
    hit_left ? {16'h0000, left_reg} :
    hit_stat ? {27'h0000000, flags_reg} : 32'h00000000;

  // bus answer: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      dat_reg <= (req & ~ack_reg) ? rd_word : dat_reg;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= `RST_IRQ_MASK;
      tor_reg <= `RST_RESP_TO;
      tod_reg <= `RST_READ_TO;
      block_byte_count_reg <= `RST_BLK_LEN;
      blocks_to_transfer_reg <= `RST_BLK_CNT;
    end else begin
      mask_reg <= mask_next;
      tor_reg <= tor_next;
      tod_reg <= tod_next;
      block_byte_count_reg <= block_byte_count_next;
      blocks_to_transfer_reg <= blocks_to_transfer_next;
    end
  end

  // status, counter and transfer state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= 5'h00;
      irq_reg <= 1'b0;
      stop_reg <= 1'b0;
      left_reg <= 16'h0000;
      inf_reg <= 1'b0;
      xstate_reg <= mmc_tobc_pkg::XFER_IDLE;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= irq_next;
      stop_reg <= done_ev;
      left_reg <= left_next;
      inf_reg <= inf_next;
      xstate_reg <= xstate_next;
    end
  end

  // outputs, all from flip-flops
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign irq_o = irq_reg;
  assign xfer_stop_o = stop_reg;
  assign xfer_active_o = (xstate_reg == mmc_tobc_pkg::XFER_RUN);
  // R14 length handed to the data engine as programmed
  assign blk_len_o = block_byte_count_reg;

  property p_resp_irq;
    @(posedge core_clk) disable iff (!rstn)
    flags_reg[`BIT_RESP_TO] && !$past(flags_reg[`BIT_RESP_TO]) && $past(mask_reg[`BIT_RESP_TO]) |-> irq_o;
  endproperty
  a_resp_irq: assert property (p_resp_irq) else $error("response time-out interrupt missing"); // R8

  property p_read_irq;
    @(posedge core_clk) disable iff (!rstn)
    flags_reg[`BIT_READ_TO] && !$past(flags_reg[`BIT_READ_TO]) && $past(mask_reg[`BIT_READ_TO]) |-> irq_o;
  endproperty
  a_read_irq: assert property (p_read_irq) else $error("read time-out interrupt missing"); // R12

  property p_irq_cause;
    @(posedge core_clk) disable iff (!rstn)
    irq_o |-> |(flags_reg & ~$past(flags_reg) & $past(mask_reg));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled rising flag"); // R18

  property p_block_byte_count_nz;
    @(posedge core_clk) disable iff (!rstn)
    blk_len_o != 12'h000;
  endproperty
  a_block_byte_count_nz: assert property (p_block_byte_count_nz) else $error("block length became zero"); // R13

  property p_blk_load;
    @(posedge core_clk) disable iff (!rstn)
    !xfer_active_o && ctrl_ev.xfer_start |=> xfer_active_o && left_reg == $past(blocks_to_transfer_reg);
  endproperty
  a_blk_load: assert property (p_blk_load) else $error("remaining count not loaded"); // R19

  sequence s_counted_block;
    xfer_active_o && !inf_reg && ctrl_ev.block_done && !ctrl_ev.stop_cmd;
  endsequence

  property p_blk_down;
    @(posedge core_clk) disable iff (!rstn)
    s_counted_block |=> left_reg == $past(left_reg) - 16'h0001;
  endproperty
  a_blk_down: assert property (p_blk_down) else $error("remaining count did not drop"); // R17

  sequence s_end_seen;
    !xfer_active_o && xfer_stop_o && flags_reg[`BIT_DATA_DONE] ##1 !xfer_stop_o;
  endsequence

  property p_blk_end;
    @(posedge core_clk) disable iff (!rstn)
    s_counted_block and left_reg == 16'h0001 |=> s_end_seen;
  endproperty
  a_blk_end: assert property (p_blk_end) else $error("transfer did not end after n blocks"); // R16

  property p_inf_run;
    @(posedge core_clk) disable iff (!rstn)
    xfer_active_o && inf_reg && !ctrl_ev.stop_cmd |=> xfer_active_o && !xfer_stop_o;
  endproperty
  a_inf_run: assert property (p_inf_run) else $error("unlimited transfer ended without stop"); // R15

  property p_bus_ack;
    @(posedge core_clk) disable iff (!rstn)
    req && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("wishbone ack timing wrong");

  // R1 R2 R3 R4 R5 masked events stay quiet
  property p_mask_gate;
    @(posedge core_clk) disable iff (!rstn)
    (ev_set & mask_reg) == 5'h00 |=> !irq_o;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("interrupt from a masked event"); // R1 R2 R3 R4 R5

  // R8 R12 event sets flag despite clear
  property p_set_wins;
    @(posedge core_clk) disable iff (!rstn)
    ev_set != 5'h00 |=> (flags_reg & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event did not set its flag"); // R8 R12

  // R15 unlimited count reads zero
  property p_inf_left;
    @(posedge core_clk) disable iff (!rstn)
    xfer_active_o && inf_reg |-> left_reg == 16'h0000;
  endproperty
  a_inf_left: assert property (p_inf_left) else $error("unlimited transfer counted blocks"); // R15
endmodule // mmc_timeout_block_count

// ---- hdl/mmc_tobc_params.svh ----
// register offsets, field positions and reset values of the time-out and block-count registers
// assumes a byte-addressed 32-bit bus with word-aligned registers
`ifndef MMC_TOBC_PARAMS_SVH
`define MMC_TOBC_PARAMS_SVH

// register byte offsets
`define OFS_IRQ_MASK 8'h00
`define OFS_RESP_TO 8'h04
`define OFS_READ_TO 8'h08
`define OFS_BLK_LEN 8'h0c
`define OFS_BLK_CNT 8'h10
`define OFS_BLK_LEFT 8'h14
`define OFS_STATUS 8'h18

// event bit positions, shared by mask and status
`define BIT_RESP_TO 4
`define BIT_READ_TO 3
`define BIT_CMD_DONE 2
`define BIT_BUSY_DONE 1
`define BIT_DATA_DONE 0
`define EVENT_W 5

// reset values
`define RST_IRQ_MASK 5'h00
`define RST_RESP_TO 16'h0000
`define RST_READ_TO 16'h0000
`define RST_BLK_LEN 12'h001
`define RST_BLK_CNT 16'h0000

`endif

// ---- hdl/mmc_tobc_pkg.sv ----
// types shared by the time-out and block-count logic
// assumes nothing beyond a SystemVerilog compiler
package mmc_tobc_pkg;

  // one-cycle pulses from the command and data engines
  typedef struct packed {
    logic cmd_sent;
    logic resp_end;
    logic read_wait;
    logic busy_end;
    logic xfer_start;
    logic block_done;
    logic stop_cmd;
  } ctrl_events_t;

  // card-side pin levels, not yet synchronised
  typedef struct packed {
    logic clk;
    logic cmd;
    logic dat0;
  } card_pins_t;

  typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;
  typedef enum logic {WAIT_IDLE, WAIT_ARMED} wait_state_t;

endpackage

// ---- hdl/mmc_wait_timer.sv ----
// wait timer: counts card clock edges while waiting for a start bit
// assumes tick and arrive are single-cycle pulses from synchronised pins
`timescale 1ns/1ps
module mmc_wait_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [23:0] limit,
  input wire logic tick,
  input wire logic arrive,
  // result
  output logic waiting,
  output logic expired
);
  mmc_tobc_pkg::wait_state_t state_reg, state_next;
  logic [23:0] count_reg, count_next;
  logic expired_reg, expired_next;
  wire last_tick = tick && (count_reg == 24'h000001);
  wire limit_on = (limit != 24'h000000);

  // start restarts the wait; arrival beats expiry on the same edge
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    expired_next = 1'b0;
    if (start) begin
      // R7 zero limit means no wait
      state_next = limit_on ? mmc_tobc_pkg::WAIT_ARMED : mmc_tobc_pkg::WAIT_IDLE;
      // R20 restart at wait start
      count_next = limit;
    end else begin
      case (state_reg)
        mmc_tobc_pkg::WAIT_IDLE: begin
          state_next = mmc_tobc_pkg::WAIT_IDLE;
        end
        mmc_tobc_pkg::WAIT_ARMED: begin
          if (arrive) begin
            // R20 stop on start bit
            state_next = mmc_tobc_pkg::WAIT_IDLE;
          end else if (last_tick) begin
            // R6 wait ran out
            state_next = mmc_tobc_pkg::WAIT_IDLE;
            expired_next = 1'b1;
          end else if (tick) begin
            count_next = count_reg - 24'h000001;
          end
        end
        default: state_next = mmc_tobc_pkg::WAIT_IDLE;
      endcase
    end
  end

  // state, count and expiry pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= mmc_tobc_pkg::WAIT_IDLE;
      count_reg <= 24'h000000;
      expired_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign waiting = (state_reg == mmc_tobc_pkg::WAIT_ARMED);
  assign expired = expired_reg;

  property p_zero_off;
    @(posedge core_clk) disable iff (!rstn)
    start && !limit_on |=> !waiting && !expired;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero limit armed the timer"); // R7

  property p_expire_cause;
    @(posedge core_clk) disable iff (!rstn)
    expired |-> $past(waiting && tick && count_reg == 24'h000001 && !arrive && !start);
  endproperty
  a_expire_cause: assert property (p_expire_cause) else $error("expiry without last tick"); // R6

  property p_arrive_stops;
    @(posedge core_clk) disable iff (!rstn)
    waiting && arrive && !start |=> !waiting && !expired;
  endproperty
  a_arrive_stops: assert property (p_arrive_stops) else $error("start bit did not stop timer"); // R20

  property p_count_down;
    @(posedge core_clk) disable iff (!rstn)
    waiting && tick && !arrive && !start && count_reg > 24'h000001 |=>
      waiting && count_reg == $past(count_reg) - 24'h000001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("timer did not count one tick"); // R6
endmodule // mmc_wait_timer

// ---- tb/mmc_card_model.sv ----
// behavioural card: gated card clock and start bits on cmd and dat0
// assumes run frames one wait; cmd and dat0 are pulled up, so idle reads high
`timescale 1ns/1ps
module mmc_card_model (
  // frame control
  input wire logic run,
  input wire logic [7:0] cmd_dly,
  input wire logic [7:0] dat_dly,
  // card pins
  output mmc_tobc_pkg::card_pins_t pins
);
  logic base = 1'b0;
  logic cmd_lvl = 1'b1;
  logic dat_lvl = 1'b1;
  int edges = 0;
  wire logic clk_gated;

  // 160 ns base, phase offset from core_clk so the two never line up
  initial begin
    #3;
    forever #80 base = ~base;
  end

  logic en = 1'b0;
  // enable moves only while base is low, so no clipped first pulse
  always @(negedge base) en <= run;
  // clock stands still outside frames
  assign clk_gated = run & en & base;

  // start bit after the chosen number of card clocks; delay 0 never answers
  always @(negedge clk_gated or negedge run) begin
    if (!run) begin
      edges <= 0;
      cmd_lvl <= 1'b1;
      dat_lvl <= 1'b1;
    end else begin
      edges <= edges + 1;
      if (cmd_dly != 0 && edges + 1 == cmd_dly) cmd_lvl <= 1'b0;
      if (dat_dly != 0 && edges + 1 == dat_dly) dat_lvl <= 1'b0;
    end
  end

  assign pins = '{clk: clk_gated, cmd: cmd_lvl, dat0: dat_lvl};
endmodule // mmc_card_model

// ---- tb/mmc_timeout_block_count_tb.sv ----
// self-checking bench: wishbone master, engine pulses and card model
// assumes offsets and field layout of mmc_tobc_params.svh
`timescale 1ns/1ps
`include "mmc_tobc_params.svh"
module mmc_timeout_block_count_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, irq_o, xfer_active_o, xfer_stop_o;
  logic [11:0] blk_len_o;
  logic [11:0] bl = 12'h001;
  mmc_tobc_pkg::card_pins_t card_pins;
  mmc_tobc_pkg::ctrl_events_t ctrl_ev = '0;
  logic run = 1'b0;
  logic [7:0] cmd_dly = 8'h00;
  logic [7:0] dat_dly = 8'h00;
  logic [31:0] seed = 32'h000101af;
  logic [31:0] q, v, mask;
  int miscompares = 0;
  int checks = 0;
  int irqs = 0;
  int stops = 0;
  int i0;

  always #5 core_clk = ~core_clk;

  mmc_timeout_block_count dut (.core_clk(core_clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .card_pins(card_pins), .ctrl_ev(ctrl_ev), .irq_o(irq_o), .xfer_active_o(xfer_active_o),
    .xfer_stop_o(xfer_stop_o), .blk_len_o(blk_len_o));

  mmc_card_model card (.run(run), .cmd_dly(cmd_dly), .dat_dly(dat_dly), .pins(card_pins));

  // count one-cycle pulses as they stand
  always @(posedge core_clk) begin
    if (irq_o === 1'b1) irqs <= irqs + 1;
    if (xfer_stop_o === 1'b1) stops <= stops + 1;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // time-out expected: enabled, reached within the run, start bit not earlier
  function automatic bit exp_to(input logic [23:0] lim, input logic [7:0] dly, input int wt);
    return lim != 0 && lim <= wt && (dly == 0 || lim <= dly);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // classic single cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1);
    // ack stands in the cycle after the request is first seen
    chk(32'(n), 32'h2, "ack latency");
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, q);
    chk(q, e, "read");
  endtask

  task automatic pulse(input mmc_tobc_pkg::ctrl_events_t e);
    @(posedge core_clk);
    ctrl_ev <= e;
    @(posedge core_clk);
    ctrl_ev <= '0;
  endtask

  // one wait for response (rw 0) or read data (rw 1)
  task automatic to_case(input bit rw, input logic [23:0] lim, input logic [7:0] dly, input bit en);
    logic e;
    int wt;
    wt = lim[7:0] + 4;
    wb(1'b1, `OFS_IRQ_MASK, {27'h0, en, en, 3'h0}, q);
    wb(1'b1, `OFS_STATUS, 32'h1f, q);
    wb(1'b1, `OFS_RESP_TO, {16'h0, lim[23:16], rw ? 8'h00 : lim[7:0]}, q);
    wb(1'b1, `OFS_READ_TO, {16'h0, lim[15:0]}, q);
    cmd_dly <= rw ? 8'h00 : dly;
    dat_dly <= rw ? dly : 8'h00;
    i0 = irqs;
    pulse(rw ? 7'h10 : 7'h40);
    run <= 1'b1;
    repeat (wt * 16) @(posedge core_clk);
    run <= 1'b0;
    e = exp_to(lim, dly, wt);
    rd(`OFS_STATUS, e ? (rw ? 32'h8 : 32'h10) : 32'h0);
    chk(32'(irqs - i0), {31'h0, e & en}, "time-out irq");
  endtask

  task automatic blk_case(input logic [15:0] n);
    int s0;
    int nb;
    mask = xs();
    wb(1'b1, `OFS_IRQ_MASK, mask, q);
    wb(1'b1, `OFS_STATUS, 32'h1f, q);
    wb(1'b1, `OFS_BLK_CNT, {16'h0, n}, q);
    s0 = stops;
    i0 = irqs;
    nb = (n == 0) ? 3 : n;
    pulse(7'h04);
    rd(`OFS_BLK_LEFT, {16'h0, n});
    chk({31'h0, xfer_active_o}, 32'h1, "active");
    for (int i = 1; i <= nb; i++) begin
      pulse(7'h02);
      rd(`OFS_BLK_LEFT, (n == 0) ? 32'h0 : 32'(n - i));
      // a second start mid-transfer must not reload
      if (i == 1 && i < nb) pulse(7'h04);
    end
    chk({31'h0, xfer_active_o}, {31'h0, n == 0}, "active after n");
    if (n == 0) pulse(7'h01);
    repeat (2) @(posedge core_clk);
    chk({31'h0, xfer_active_o}, 32'h0, "active at end");
    chk(32'(stops - s0), 32'h1, "stop pulse");
    rd(`OFS_STATUS, 32'h1);
    chk(32'(irqs - i0), {31'h0, mask[0]}, "data done irq");
  endtask

  initial begin
    #900000;
    chk(32'h0, 32'h1, "watchdog");
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(`OFS_IRQ_MASK, 32'h0);
    rd(`OFS_BLK_LEN, 32'h1);
    rd(`OFS_BLK_LEFT, 32'h0);
    // first pass writes zero: block length must keep its old value
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'h0 : xs();
      for (int a = 0; a < 8; a++) wb(1'b1, 8'(a * 4), v, q);
      if (v[11:0] != 0) bl = v[11:0];
      rd(`OFS_IRQ_MASK, v & 32'h1f);
      rd(`OFS_RESP_TO, v & 32'hffff);
      rd(`OFS_READ_TO, v & 32'hffff);
      rd(`OFS_BLK_LEN, {20'h0, bl});
      rd(`OFS_BLK_CNT, v & 32'hffff);
      rd(`OFS_BLK_LEFT, 32'h0);
      rd(8'h1c, 32'h0);
      chk({20'h0, blk_len_o}, {20'h0, bl}, "blk_len_o");
    end
    to_case(1'b0, 24'h3, 8'h05, 1'b1);
    to_case(1'b0, 24'h6, 8'h05, 1'b1);
    to_case(1'b0, 24'h0, 8'h00, 1'b1);
    to_case(1'b0, 24'h2, 8'h00, 1'b0);
    to_case(1'b1, 24'h4, 8'h00, 1'b1);
    to_case(1'b1, 24'h5, 8'h05, 1'b1);
    to_case(1'b1, 24'h010002, 8'h00, 1'b1);
    to_case(1'b1, 24'h0, 8'h00, 1'b1);
    to_case(1'b1, 24'h3, 8'h00, 1'b0);
    for (int k = 0; k < 4; k++) begin
      mask = xs();
      wb(1'b1, `OFS_IRQ_MASK, mask, q);
      wb(1'b1, `OFS_STATUS, 32'h1f, q);
      i0 = irqs;
      pulse(k[0] ? 7'h08 : 7'h20);
      rd(`OFS_STATUS, k[0] ? 32'h2 : 32'h4);
      chk(32'(irqs - i0), {31'h0, mask[k[0] ? 1 : 2]}, "event irq");
      pulse(k[0] ? 7'h08 : 7'h20);
      repeat (2) @(posedge core_clk);
      chk(32'(irqs - i0), {31'h0, mask[k[0] ? 1 : 2]}, "held flag irq");
    end
    blk_case(16'h0001);
    blk_case(16'h0000);
    for (int j = 0; j < 2; j++) blk_case(16'(xs() % 4 + 2));
    wrap_up();
  end
endmodule // mmc_timeout_block_count_tb
